// file: dma_channel_event_trigger.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module dma_channel_event_trigger #(
  parameter int NUM_CH = dma_evt_pkg::NUM_CH,
  parameter int IRQ_N  = dma_evt_pkg::IRQ_N
) (
  input  wire logic             mclk,      // System clock, 200 MHz
  input  wire logic             rstn,      // Async reset, active low
  input  wire logic [7:0]       reg_addr,  // Register word address
  input  wire logic [31:0]      reg_wdata, // Register write data
  input  wire logic             reg_wr,    // Write strobe
  input  wire logic             reg_rd,    // Read strobe
  output logic [31:0]           reg_rdata, // Read data, next cycle
  input  wire logic [IRQ_N-1:0] irq_lines, // Interrupt request lines
  output dma_evt_pkg::mem_req_s mem_req,   // Bus request to memory
  input  wire logic             mem_ack,   // Bus access done
  input  wire logic             mem_err,   // Invalid address
  input  wire logic [7:0]       mem_rdata, // Bus read byte
  output logic                  irq_out    // Interrupt, level
);
  import dma_evt_pkg::*;

  if (NUM_CH < 1 || NUM_CH > 4 || IRQ_N != 256) begin : g_chk
    $error("NUM_CH must be 1..4 and IRQ_N must be 256");
  end

  // ---------------------------------------------------------------
  // Shared state
  // ---------------------------------------------------------------
  eng_state_e              eng_state;
  logic [1:0]              eng_ch;
  logic [1:0]              next_ch;
  logic                    any_req;
  logic [NUM_CH-1:0]       pend_v;
  logic [NUM_CH-1:0]       en_v;
  logic [NUM_CH-1:0]       pat_en_v;
  logic [NUM_CH-1:0]       blk_v;
  logic [31:0]             src_addr [NUM_CH];
  logic [31:0]             dst_addr [NUM_CH];
  logic [SIZE_W-1:0]       src_ptr  [NUM_CH];
  logic [SIZE_W-1:0]       dst_ptr  [NUM_CH];
  logic [7:0]              pattern  [NUM_CH];
  logic [31:0]             ch_word  [NUM_CH];
  logic [NUM_CH*EV_W-1:0]  ev_all;
  logic [NUM_CH*EV_W-1:0]  int_stat;
  logic [NUM_CH*EV_W-1:0]  int_mask;
  logic [31:0]             last_addr;
  logic [1:0]              last_ch;
  logic [31:0]             crc_ctrl;
  logic [15:0]             crc_val;
  logic [31:0]             rd_val;
  logic                    step;
  logic                    pat_hit;
  logic                    err_hit;
  logic                    ch_region;
  logic [1:0]              ch_idx;
  logic [2:0]              reg_sel;

  assign ch_region = reg_addr[7:5] == 3'h0;
  assign ch_idx    = reg_addr[4:3];
  assign reg_sel   = reg_addr[2:0];

  // Byte-wide CRC, MSB first, polynomial from the control register
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d,
                                           input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      if (r[15] ^ d[b]) begin
        r = {r[14:0], 1'b0} ^ p;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Arbitration and transfer engine
  // ---------------------------------------------------------------
  // Lowest channel number wins; scanned high to low so it lands last
  always_comb begin
    any_req = 1'b0;
    next_ch = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_v[i] && en_v[i]) begin
        any_req = 1'b1;
        next_ch = 2'(i);
      end
    end
  end

  // Completed byte write; an aborted channel's write is not counted
  assign step    = eng_state == ST_WRITE && mem_ack && !mem_err &&
                   pend_v[eng_ch];
  assign pat_hit = eng_state == ST_READ && mem_ack && !mem_err &&
                   pat_en_v[eng_ch] && mem_rdata == pattern[eng_ch];
  assign err_hit = eng_state != ST_IDLE && mem_ack && mem_err;

  // One byte per read/write pair, so no alignment is ever required
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      eng_state <= ST_IDLE;
      eng_ch    <= 2'h0;
      mem_req   <= '0;
    end else begin
      case (eng_state)
        ST_IDLE: begin
          if (any_req) begin
            eng_ch        <= next_ch;
            mem_req.valid <= 1'b1;
            mem_req.we    <= 1'b0;
            mem_req.addr  <= src_addr[next_ch] +
                             32'(src_ptr[next_ch]);
            eng_state     <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            if (mem_err || pat_hit || !pend_v[eng_ch]) begin
              mem_req.valid <= 1'b0;
              eng_state     <= ST_IDLE;
            end else begin
              mem_req.we    <= 1'b1;
              mem_req.addr  <= dst_addr[eng_ch] +
                               32'(dst_ptr[eng_ch]);
              mem_req.wdata <= mem_rdata;
              eng_state     <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_req.valid <= 1'b0;
            eng_state     <= ST_IDLE;
          end
        end
        default: begin
          mem_req.valid <= 1'b0;
          eng_state     <= ST_IDLE;
        end
      endcase
    end
  end

  // Debug trace of the last bus address and the last mover
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_addr <= 32'h0000_0000;
      last_ch   <= 2'h0;
    end else begin
      if (mem_req.valid && mem_ack) begin
        last_addr <= mem_req.addr;
      end
      if (step) begin
        last_ch <= eng_ch;
      end
    end
  end

  // CRC control and running value
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crc_ctrl <= {CRC_POLY_RESET, 16'h0000};
      crc_val  <= CRC_SEED_RESET;
    end else begin
      if (reg_wr && reg_addr == REG_CRC_CTRL) begin
        crc_ctrl <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_CRC_DATA) begin
        crc_val <= reg_wdata[15:0];
      end else if (step && crc_ctrl[CRC_EN] &&
                   eng_ch == crc_ctrl[CRC_CH_LSB +: 2]) begin
        crc_val <= crc_byte(crc_val, mem_req.wdata,
                            crc_ctrl[CRC_POLY_LSB +: 16]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    econ_s             econ;
    econ_s             wr_econ;
    logic [2:0]        ctrl;
    logic              pend;
    logic [SIZE_W-1:0] src_size;
    logic [SIZE_W-1:0] dst_size;
    logic [SIZE_W-1:0] cell_size;
    logic [SIZE_W-1:0] cell_cnt;
    logic              wr_sel;
    logic              start_hit;
    logic              abort_hit;
    logic              force_hit;
    logic              strobe_abort;
    logic              mine;
    logic              my_step;
    logic              kill;
    logic              src_wrap;
    logic              dst_wrap;
    logic              cell_end;
    logic              blk;

    assign wr_sel  = reg_wr && ch_region && ch_idx == 2'(i);
    assign wr_econ = econ_s'(reg_wdata);
    assign mine    = eng_ch == 2'(i) && eng_state != ST_IDLE;
    assign my_step = step && mine;

    // Interrupt triggers and software strobes
    assign start_hit = econ.start_irq_enable &&
                       irq_lines[econ.start_irq_select];
    assign abort_hit = econ.abort_irq_enable &&
                       irq_lines[econ.abort_irq_select];
    assign force_hit = wr_sel && reg_sel == REG_CH_ECON &&
                       wr_econ.force_transfer_strobe;
    assign strobe_abort = wr_sel && reg_sel == REG_CH_ECON &&
                          wr_econ.abort_transfer_strobe;
    assign kill = abort_hit || strobe_abort ||
                  (mine && (pat_hit || err_hit));

    assign src_wrap = src_ptr[i] + 16'd1 >= src_size;
    assign dst_wrap = dst_ptr[i] + 16'd1 >= dst_size;
    assign cell_end = cell_cnt + 16'd1 >= cell_size;
    assign blk      = my_step && dst_wrap;

    assign pend_v[i]   = pend;
    assign en_v[i]     = ctrl[CTRL_EN];
    assign pat_en_v[i] = econ.pattern_abort_enable;
    assign blk_v[i]    = blk;

    // Strobes and unused bits never store, so they read as zero
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        econ <= econ_s'(ECON_RESET);
      end else if (wr_sel && reg_sel == REG_CH_ECON) begin
        econ <= econ_s'(reg_wdata & ECON_WMASK);
      end
    end

    // Enable, auto-repeat and chain; chained set wins over a clear
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        ctrl <= 3'h0;
      end else begin
        if (wr_sel && reg_sel == REG_CH_CTRL) begin
          ctrl <= reg_wdata[2:0];
        end
        if (blk) begin
          ctrl[CTRL_EN] <= ctrl[CTRL_AUTO];
        end
        if (mine && (pat_hit || err_hit)) begin
          ctrl[CTRL_EN] <= 1'b0;
        end
        if (ctrl[CTRL_CHAIN] && i > 0 && blk_v[(i + NUM_CH - 1) % NUM_CH])
        begin
          ctrl[CTRL_EN] <= 1'b1;
        end
      end
    end

    // Cell request: end of cell clears, trigger sets, abort beats both
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        pend <= 1'b0;
      end else begin
        if (my_step && (cell_end || dst_wrap)) begin
          pend <= 1'b0;
        end
        if ((start_hit || force_hit) && ctrl[CTRL_EN]) begin
          pend <= 1'b1;
        end
        if (kill) begin
          pend <= 1'b0;
        end
      end
    end

    // Pointers advance per byte and rewind at block end or abort
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        src_ptr[i] <= '0;
        dst_ptr[i] <= '0;
        cell_cnt   <= '0;
      end else if (kill) begin
        src_ptr[i] <= '0;
        dst_ptr[i] <= '0;
        cell_cnt   <= '0;
      end else if (my_step) begin
        src_ptr[i] <= (src_wrap || blk) ? '0 : src_ptr[i] + 16'd1;
        dst_ptr[i] <= dst_wrap ? '0 : dst_ptr[i] + 16'd1;
        cell_cnt   <= (cell_end || blk) ? '0 : cell_cnt + 16'd1;
      end
    end

    // Addresses, sizes and pattern belong to this channel alone
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        src_addr[i] <= 32'h0000_0000;
        dst_addr[i] <= 32'h0000_0000;
        src_size    <= '0;
        dst_size    <= '0;
        cell_size   <= '0;
        pattern[i]  <= 8'h00;
      end else if (wr_sel) begin
        case (reg_sel)
          REG_CH_SRC:     src_addr[i] <= reg_wdata;
          REG_CH_DST:     dst_addr[i] <= reg_wdata;
          REG_CH_SRC_SZ:  src_size    <= reg_wdata[SIZE_W-1:0];
          REG_CH_DST_SZ:  dst_size    <= reg_wdata[SIZE_W-1:0];
          REG_CH_CELL_SZ: cell_size   <= reg_wdata[SIZE_W-1:0];
          REG_CH_PATTERN: pattern[i]  <= reg_wdata[7:0];
          default: begin
          end
        endcase
      end
    end

    // Status events of this channel
    assign ev_all[i*EV_W+EV_BLOCK]     = blk;
    assign ev_all[i*EV_W+EV_SRC_HALF]  = my_step &&
                                         src_ptr[i] + 16'd1 == src_size >> 1;
    assign ev_all[i*EV_W+EV_SRC_EMPTY] = my_step && src_wrap;
    assign ev_all[i*EV_W+EV_DST_HALF]  = my_step &&
                                         dst_ptr[i] + 16'd1 == dst_size >> 1;
    assign ev_all[i*EV_W+EV_DST_FULL]  = blk;
    assign ev_all[i*EV_W+EV_ABORT]     = abort_hit;
    assign ev_all[i*EV_W+EV_ADDR_ERR]  = mine && err_hit;
    assign ev_all[i*EV_W+7]            = 1'b0;

    // Read view of this channel
    always_comb begin
      case (reg_sel)
        REG_CH_CTRL:    ch_word[i] = {24'h0, pend, 4'h0, ctrl};
        REG_CH_ECON:    ch_word[i] = econ;
        REG_CH_SRC:     ch_word[i] = src_addr[i];
        REG_CH_DST:     ch_word[i] = dst_addr[i];
        REG_CH_SRC_SZ:  ch_word[i] = {16'h0, src_size};
        REG_CH_DST_SZ:  ch_word[i] = {16'h0, dst_size};
        REG_CH_CELL_SZ: ch_word[i] = {16'h0, cell_size};
        REG_CH_PATTERN: ch_word[i] = {24'h0, pattern[i]};
        default:        ch_word[i] = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and register read
  // ---------------------------------------------------------------
  // Reading the status clears it, but a same-cycle event survives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      int_stat <= ((reg_rd && reg_addr == REG_INT_STAT) ? '0 : int_stat)
                  | ev_all;
      if (reg_wr && reg_addr == REG_INT_MASK) begin
        int_mask <= reg_wdata[NUM_CH*EV_W-1:0];
      end
    end
  end

  assign irq_out = |(int_stat & int_mask);

  always_comb begin
    if (ch_region) begin
      rd_val = (32'(ch_idx) < NUM_CH) ? ch_word[ch_idx] : 32'h0;
    end else begin
      case (reg_addr)
        REG_INT_STAT: rd_val = 32'(int_stat);
        REG_INT_MASK: rd_val = 32'(int_mask);
        REG_DBG_ADDR: rd_val = last_addr;
        REG_DBG_CHAN: rd_val = {30'h0, last_ch};
        REG_CRC_CTRL: rd_val = crc_ctrl;
        REG_CRC_DATA: rd_val = {16'h0, crc_val};
        default:      rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

endmodule

// file: dma_evt_pkg.sv
package dma_evt_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int IRQ_N  = 256;
  localparam int SIZE_W = 16;
  localparam int EV_W   = 8;

  // ---------------------------------------------------------------
  // Register word addresses
  // ---------------------------------------------------------------
  // Channel n occupies words n*8 .. n*8+7, selected by addr[2:0]
  localparam logic [2:0] REG_CH_CTRL    = 3'h0;
  localparam logic [2:0] REG_CH_ECON    = 3'h1;
  localparam logic [2:0] REG_CH_SRC     = 3'h2;
  localparam logic [2:0] REG_CH_DST     = 3'h3;
  localparam logic [2:0] REG_CH_SRC_SZ  = 3'h4;
  localparam logic [2:0] REG_CH_DST_SZ  = 3'h5;
  localparam logic [2:0] REG_CH_CELL_SZ = 3'h6;
  localparam logic [2:0] REG_CH_PATTERN = 3'h7;
  localparam logic [7:0] REG_INT_STAT   = 8'h20;
  localparam logic [7:0] REG_INT_MASK   = 8'h21;
  localparam logic [7:0] REG_DBG_ADDR   = 8'h22;
  localparam logic [7:0] REG_DBG_CHAN   = 8'h23;
  localparam logic [7:0] REG_CRC_CTRL   = 8'h24;
  localparam logic [7:0] REG_CRC_DATA   = 8'h25;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN    = 0;
  localparam int CTRL_AUTO  = 1;
  localparam int CTRL_CHAIN = 2;
  localparam int CTRL_BUSY  = 7;
  localparam int EV_BLOCK     = 0;
  localparam int EV_SRC_HALF  = 1;
  localparam int EV_SRC_EMPTY = 2;
  localparam int EV_DST_HALF  = 3;
  localparam int EV_DST_FULL  = 4;
  localparam int EV_ABORT     = 5;
  localparam int EV_ADDR_ERR  = 6;
  localparam int CRC_EN       = 0;
  localparam int CRC_CH_LSB   = 1;
  localparam int CRC_POLY_LSB = 16;

  // ---------------------------------------------------------------
  // Event control word and reset values
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] unused_hi;
    logic [7:0] abort_irq_select;
    logic [7:0] start_irq_select;
    logic       force_transfer_strobe;
    logic       abort_transfer_strobe;
    logic       pattern_abort_enable;
    logic       start_irq_enable;
    logic       abort_irq_enable;
    logic [2:0] unused_lo;
  } econ_s;

  localparam logic [31:0] ECON_RESET     = 32'h00ff_ff00;
  localparam logic [31:0] ECON_WMASK     = 32'h00ff_ff38;
  localparam logic [15:0] CRC_POLY_RESET = 16'h1021;
  localparam logic [15:0] CRC_SEED_RESET = 16'hffff;

  // ---------------------------------------------------------------
  // System bus request and engine states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} eng_state_e;

endpackage

// file: dma_evt_monitor.sv
`timescale 1ns/10ps
module dma_evt_monitor #(
  parameter int NUM_CH = 4,
  parameter int IRQ_N  = 256
) (
  input wire logic                  mclk,      // Clock
  input wire logic                  rstn,      // Reset, active low
  input wire logic [7:0]            reg_addr,  // Register address
  input wire logic [31:0]           reg_wdata, // Write data
  input wire logic                  reg_wr,    // Write strobe
  input wire logic                  reg_rd,    // Read strobe
  input wire logic [31:0]           reg_rdata, // Read data
  input wire logic [IRQ_N-1:0]      irq_lines, // Trigger lines
  input wire dma_evt_pkg::mem_req_s mem_req,   // Bus request
  input wire logic                  mem_ack,   // Bus done
  input wire logic                  mem_err,   // Bad address
  input wire logic [7:0]            mem_rdata, // Bus read byte
  input wire logic                  irq_out    // Interrupt
);
  import dma_evt_pkg::*;

  // ---------------------------------------------------------------
  // Register port and reset
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  AST_ECON_ZEROS: assert property (reg_rd && reg_addr[7:5] == 3'h0 &&
      reg_addr[2:0] == REG_CH_ECON |=> (reg_rdata & ~ECON_WMASK) == '0)
    else $error("event control unused bits read non-zero");
  AST_RESET_QUIET: assert property ($rose(rstn) |-> !mem_req.valid &&
      !irq_out && reg_rdata == '0)
    else $error("outputs busy right after reset");
  // Status can only drop through a read or a mask write
  AST_IRQ_CLEAR: assert property ($fell(irq_out) |->
      $past(reg_rd) || $past(reg_wr))
    else $error("interrupt dropped without register access");

  // ---------------------------------------------------------------
  // System bus
  // ---------------------------------------------------------------
  AST_REQ_HOLD: assert property (mem_req.valid && !mem_ack |=>
      mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.we))
    else $error("request changed before acknowledge");
  AST_BYTE_COPY: assert property (mem_req.valid && !mem_req.we
      && mem_ack && !mem_err |=> !mem_req.valid ||
      mem_req.we && mem_req.wdata == $past(mem_rdata))
    else $error("written byte differs from byte read");
  AST_IDLE_GAP: assert property (mem_req.valid && mem_req.we && mem_ack
      |=> !mem_req.valid)
    else $error("no idle cycle after write");
  // A request needs a trigger or a finished access two cycles before
  AST_REQ_CAUSE: assert property ($rose(mem_req.valid) |->
      $past(reg_wr, 2) || $past(|irq_lines, 2) || $past(mem_ack, 2))
    else $error("request without cause");

  COV_WRITE: cover property (mem_req.valid && mem_req.we && mem_ack);
  COV_ERR: cover property (mem_ack && mem_err);
  COV_IRQ: cover property ($rose(irq_out));
endmodule

bind dma_channel_event_trigger dma_evt_monitor #(
  .NUM_CH(NUM_CH), .IRQ_N(IRQ_N)) u_mon (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_lines(irq_lines), .mem_req(mem_req), .mem_ack(mem_ack),
  .mem_err(mem_err), .mem_rdata(mem_rdata), .irq_out(irq_out));

// file: dma_mem_model.sv
`timescale 1ns/10ps
module dma_mem_model (
  input wire logic                  mclk,     // Clock
  input wire logic                  rstn,     // Reset, active low
  input wire dma_evt_pkg::mem_req_s mem_req,  // Engine request
  input wire logic                  slow,     // Four-cycle accesses
  output logic                      mem_ack,  // One-cycle done
  output logic                      mem_err,  // Bad address
  output logic [7:0]                mem_rdata // Read byte
);
  import dma_evt_pkg::*;
  logic [1:0] wait_cnt;

  // Byte memory; top nibble f is an unmapped hole. Idle data keeps
  // toggling so a stale byte is never mistaken for a fresh one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt  <= 2'h0;
    end else if (!mem_ack && mem_req.valid &&
                 (!slow || wait_cnt == 2'h3)) begin
      mem_ack   <= 1'b1;
      mem_err   <= mem_req.addr[31:28] == 4'hf;
      mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= wait_cnt + 2'(mem_req.valid && !mem_ack);
    end
  end
endmodule

// file: tb_dma_channel_event_trigger.sv
`timescale 1ns/10ps
module tb_dma_channel_event_trigger;
  import dma_evt_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;

  logic             mclk, rstn, reg_wr, reg_rd, slow;
  logic             mem_ack, mem_err, irq_out;
  logic [7:0]       reg_addr, mem_rdata;
  logic [31:0]      reg_wdata, reg_rdata, rv;
  logic [IRQ_N-1:0] irq_lines;
  mem_req_s         mem_req;
  logic [31:0]      wa_q[$], ra_q[$];
  logic [7:0]       wd_q[$];
  int               error_cnt = 0;
  int               num_checks = 0;
  int               cyc = 0;

  // Register rows: write?, address, data, expected read
  row_s rows [7] = '{
    '{1'b0, 8'h01, 32'h0, ECON_RESET},
    '{1'b0, 8'h19, 32'h0, ECON_RESET},
    '{1'b1, 8'h09, 32'hffff_ffff, 32'h00ff_ff38},
    '{1'b1, 8'h11, 32'h1234_5678, 32'h0034_5638},
    '{1'b1, 8'h30, 32'hffff_ffff, 32'h0},
    '{1'b1, REG_INT_MASK, 32'hff, 32'hff},
    '{1'b0, REG_CRC_DATA, 32'h0, 32'hffff}};

  dma_channel_event_trigger uut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_lines(irq_lines), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata), .irq_out(irq_out));

  dma_mem_model mem (
    .mclk(mclk), .rstn(rstn), .mem_req(mem_req), .slow(slow),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // Clock, access log, run ceiling
  // ---------------------------------------------------------------
  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (mem_req.valid && mem_ack && mem_req.we) begin
      wa_q.push_back(mem_req.addr);
      wd_q.push_back(mem_req.wdata);
    end
    if (mem_req.valid && mem_ack && !mem_req.we) ra_q.push_back(mem_req.addr);
  end

  // Whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task finish_test();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function logic [7:0] ra(input int c, input logic [2:0] o);
    return {c[4:0], o};
  endfunction

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // Event control goes last so a force sees the finished setup
  task setup(input int c, input logic [31:0] s, d, n, ec);
    wr(ra(c, REG_CH_SRC), s);
    wr(ra(c, REG_CH_DST), d);
    wr(ra(c, REG_CH_SRC_SZ), n);
    wr(ra(c, REG_CH_DST_SZ), n);
    wr(ra(c, REG_CH_CELL_SZ), n);
    wr(ra(c, REG_CH_CTRL), 32'h1);
    wr(ra(c, REG_CH_ECON), ec);
  endtask

  task pulse(input int i, input int j);
    @(posedge mclk);
    irq_lines <= (IRQ_N'(1) << i) | (IRQ_N'(1) << j);
    @(posedge mclk);
    irq_lines    <= '0;
  endtask

  // Bounded wait for eight quiet bus cycles
  task settle();
    int q;
    q = 0;
    for (int k = 0; k < 400 && q < 8; k++) begin
      @(posedge mclk);
      q = mem_req.valid ? 0 : q + 1;
    end
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    irq_lines = '0;
    slow = 1'b1;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rv, rows[i].e);
    end
    // Forced two-byte block against slow memory
    setup(0, 32'h100, 32'h200, 32'h2, 32'h00ff_ff80);
    settle();
    chk(32'(wa_q.size()), 32'h2);
    chk(wa_q[1], 32'h201);
    chk(32'(wd_q[1]), 32'h5b);
    rd(ra(0, REG_CH_ECON));
    chk(rv, ECON_RESET);
    rd(ra(0, REG_CH_CTRL));
    chk(32'(rv[CTRL_EN]), 32'h0);
    chk(32'(irq_out), 32'h1);
    rd(REG_INT_STAT);
    chk(32'(rv[EV_BLOCK]), 32'h1);
    chk(32'(irq_out), 32'h0);
    // Start line: wrong number, right number, then gated off
    slow <= 1'b0;
    setup(1, 32'h300, 32'h400, 32'h1, 32'h00ff_2110);
    pulse(8'h20, 8'h20);
    settle();
    chk(32'(wa_q.size()), 32'h2);
    pulse(8'h21, 8'h21);
    settle();
    chk(32'(wa_q.size()), 32'h3);
    wr(ra(1, REG_CH_CTRL), 32'h1);
    wr(ra(1, REG_CH_ECON), 32'h00ff_2100);
    pulse(8'h21, 8'h21);
    settle();
    chk(32'(wa_q.size()), 32'h3);
    // Abort beside start in one cycle, then abort gated off
    rd(REG_INT_STAT);
    wr(ra(1, REG_CH_ECON), 32'h0022_2118);
    pulse(8'h21, 8'h22);
    settle();
    chk(32'(wa_q.size()), 32'h3);
    rd(REG_INT_STAT);
    chk(32'(rv[8+EV_ABORT]), 32'h1);
    wr(ra(1, REG_CH_ECON), 32'h0022_2110);
    pulse(8'h22, 8'h22);
    settle();
    rd(REG_INT_STAT);
    chk(32'(rv[8+EV_ABORT]), 32'h0);
    // Two channels on one start line
    setup(2, 32'h500, 32'h600, 32'h1, 32'h00ff_4010);
    setup(0, 32'h180, 32'h280, 32'h1, 32'h00ff_4010);
    wr(ra(0, REG_CH_CTRL), 32'h3);
    pulse(8'h40, 8'h40);
    settle();
    chk(ra_q[ra_q.size()-2], 32'h180);
    chk(ra_q[ra_q.size()-1], 32'h500);
    chk(32'(wa_q.size()), 32'h5);
    rd(ra(0, REG_CH_CTRL));
    chk(32'(rv[CTRL_EN]), 32'h1);
    rd(REG_DBG_CHAN);
    chk(rv, 32'h2);
    rd(REG_DBG_ADDR);
    chk(rv, 32'h600);
    // Pattern byte stops the channel unwritten, unless disabled
    wr(ra(3, REG_CH_PATTERN), 32'h5a);
    setup(3, 32'h700, 32'h800, 32'h1, 32'h00ff_ffa0);
    settle();
    chk(32'(wa_q.size()), 32'h5);
    wr(REG_CRC_CTRL, 32'h1021_0007);
    setup(3, 32'h700, 32'h800, 32'h1, 32'h00ff_ff80);
    settle();
    chk(32'(wa_q.size()), 32'h6);
    rd(REG_CRC_DATA);
    chk(rv, 32'h1a4f);
    // Bad address under a mask, then unmasked
    wr(REG_INT_MASK, 32'h0);
    rd(REG_INT_STAT);
    setup(3, 32'hf000_0000, 32'h900, 32'h1, 32'h00ff_ff80);
    settle();
    chk(32'(irq_out), 32'h0);
    wr(REG_INT_MASK, 32'hffff_ffff);
    #1;
    chk(32'(irq_out), 32'h1);
    rd(REG_INT_STAT);
    chk(32'(rv[24+EV_ADDR_ERR]), 32'h1);
    // Force and abort in one write
    setup(2, 32'ha00, 32'hb00, 32'h1, 32'h00ff_ffc0);
    settle();
    chk(32'(wa_q.size()), 32'h6);
    // Second reset mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(ra(2, REG_CH_ECON));
    chk(rv, ECON_RESET);
    finish_test();
  end
endmodule
